// [include/rsf_pkg.sv]
// Package for the reset source flag block.
// Assumes a 32-bit APB slave port on byte addresses.
package rsf_pkg;

   // Bus, register and counter widths.
   localparam int RSF_DATA_W = 32;
   localparam int RSF_ADDR_W = 8;
   localparam int RSF_REG_W  = 8;
   localparam int RSF_CNT_W  = 8;

   // Register index of the cause flags; byte address is four times it.
   localparam logic [7:0] RSF_CAUSE_IDX  = 8'h03;
   localparam logic [7:0] RSF_CAUSE_ADDR = {RSF_CAUSE_IDX[5:0], 2'b00};

   // Further registers, byte addresses.
   localparam logic [7:0] RSF_STAT_ADDR  = 8'h20;
   localparam logic [7:0] RSF_MASK_ADDR  = 8'h24;
   localparam logic [7:0] RSF_LAST_ADDR  = 8'h28;
   localparam logic [7:0] RSF_CNT_ADDR   = 8'h2c;
   localparam logic [7:0] RSF_CTRL_ADDR  = 8'h30;

   // Bit positions of the cause flags.
   localparam int RSF_BIT_PLL  = 0;
   localparam int RSF_BIT_OSC  = 1;
   localparam int RSF_BIT_WDOG = 3;
   localparam int RSF_BIT_LV   = 5;
   localparam int RSF_BIT_POR  = 6;

   // Implemented flag bits and their value after power-on.
   localparam logic [7:0] RSF_FLAGS_IMPL = 8'h6b;
   localparam logic [7:0] RSF_FLAGS_POR  = 8'h60;

   // Reset values of the own registers, and the counter limit.
   localparam logic [7:0] RSF_MASK_RST   = 8'h00;
   localparam logic [7:0] RSF_STAT_RST   = 8'h00;
   localparam logic [7:0] RSF_CNT_RST    = 8'h00;
   localparam logic [7:0] RSF_CNT_MAX    = 8'hff;

   // Control register: bit that clears the event counters.
   localparam int RSF_CTRL_CNT_CLR = 0;

   // Most recent reset cause.
   typedef enum logic [2:0] {
      RSF_C_POR,
      RSF_C_LV,
      RSF_C_WDOG,
      RSF_C_OSC,
      RSF_C_PLL
   } rsf_cause_e;

   // Single-cycle reset source events from the reset generator.
   typedef struct packed {
      logic lv;
      logic wdog;
      logic osc;
      logic pll;
   } rsf_events_s;

endpackage

// [logic/rsf_flag_cell.sv]
// One sticky reset cause flag with write-one-to-clear.
// Assumes set and clear are single-cycle terms on pclk.
`timescale 1ns/10ps

module rsf_flag_cell
   import rsf_pkg::*;
#(
   parameter logic POR_VALUE = 1'b0
) (
   input  wire logic pclk,   // Bus clock.
   input  wire logic por_n,  // Power-on reset, active low.
   input  wire logic set,    // Reset source event.
   input  wire logic clr,    // Software wrote a one.
   output logic      flag    // Flag state.
);

   // The flag keeps its value across system resets; only power-on
   // loads it. A set in the clearing cycle wins.
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         flag <= POR_VALUE;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clr) begin
         flag <= 1'b0;
      end
   end

endmodule

// [logic/rsf_reset_cause.sv]
// Reset cause recording with APB register access and interrupt.
// Assumes events arrive as single-cycle pulses on pclk, and that
// por_n is the power-on reset while presetn is the system reset.
//
// Function
// - Power-on reset sets power-on flag, bit 6.
// - Low-voltage reset sets low-voltage flag, bit 5.
// - Power-on reset also sets low-voltage flag.
// - Watchdog reset sets watchdog flag, bit 3.
// - Oscillator loss sets oscillator-loss flag, bit 1.
// - PLL loss sets PLL-loss flag, bit 0.
// - Power-on clears watchdog, oscillator, PLL flags.
// - System reset leaves every flag unchanged.
// - Apart from power-on, flags clear only on written one.
`timescale 1ns/10ps

module rsf_reset_cause
   import rsf_pkg::*;
(
   input  wire logic                  pclk,        // Bus clock.
   input  wire logic                  presetn,     // System reset.
   input  wire logic                  por_n,       // Power-on reset.
   input  wire logic [RSF_ADDR_W-1:0] paddr,       // APB address.
   input  wire logic                  psel,        // APB select.
   input  wire logic                  penable,     // APB enable.
   input  wire logic                  pwrite,      // APB direction.
   input  wire logic [RSF_DATA_W-1:0] pwdata,      // APB write data.
   input  wire logic [3:0]            pstrb,       // APB byte lanes.
   output logic      [RSF_DATA_W-1:0] prdata,      // APB read data.
   output logic                       pready,      // APB ready.
   output logic                       pslverr,     // APB error.
   input  wire rsf_events_s           events,      // Source events.
   output logic      [RSF_REG_W-1:0]  cause_flags, // Flag register.
   output logic                       irq          // Interrupt.
);

   // Address map check, shared by read and write paths.
   function automatic logic addr_mapped(input logic [7:0] a);
      begin
         addr_mapped = (a == RSF_CAUSE_ADDR) ||
                       (a == RSF_STAT_ADDR)  ||
                       (a == RSF_MASK_ADDR)  ||
                       (a == RSF_LAST_ADDR)  ||
                       (a == RSF_CNT_ADDR)   ||
                       (a == RSF_CTRL_ADDR);
      end
   endfunction

   // Registers that refuse writes.
   function automatic logic addr_read_only(input logic [7:0] a);
      begin
         addr_read_only = (a == RSF_LAST_ADDR) ||
                          (a == RSF_CNT_ADDR);
      end
   endfunction

   // Saturating event counter step.
   function automatic logic [RSF_CNT_W-1:0] sat_inc(
      input logic [RSF_CNT_W-1:0] v,
      input logic                 ev
   );
      begin
         if (ev && (v != RSF_CNT_MAX)) begin
            sat_inc = v + 8'h01;
         end else begin
            sat_inc = v;
         end
      end
   endfunction

   // Bus phase terms.
   logic                  setup;
   logic                  access;
   logic                  wr_ok;
   logic                  wr_cause;
   logic                  wr_mask;
   logic                  wr_ctrl;
   logic                  rd_stat;

   // Register state.
   logic [RSF_DATA_W-1:0] prdata_reg;
   logic                  pslverr_reg;
   logic [RSF_REG_W-1:0]  stat_cap_reg;
   logic [RSF_REG_W-1:0]  stat_reg;
   logic [RSF_REG_W-1:0]  stat_next;
   logic [RSF_REG_W-1:0]  mask_reg;
   logic [RSF_REG_W-1:0]  seen_reg;
   logic                  irq_reg;
   rsf_cause_e            last_reg;
   logic [RSF_CNT_W-1:0]  cnt_lv_reg;
   logic [RSF_CNT_W-1:0]  cnt_wdog_reg;
   logic [RSF_CNT_W-1:0]  cnt_osc_reg;
   logic [RSF_CNT_W-1:0]  cnt_pll_reg;

   // Flag terms.
   logic [RSF_REG_W-1:0]  flag_set;
   logic [RSF_REG_W-1:0]  flag_clr;
   logic [RSF_REG_W-1:0]  flags;
   logic [RSF_REG_W-1:0]  flag_rise;
   logic                  cnt_clr;

   // Phases of an APB transfer; the slave never waits.
   assign setup  = psel & ~penable;
   assign access = psel & penable;
   assign pready = 1'b1;

   // A write takes effect at the access edge, on lane 0 only.
   assign wr_ok    = access & pwrite & ~pslverr_reg & pstrb[0];
   assign wr_cause = wr_ok & (paddr == RSF_CAUSE_ADDR);
   assign wr_mask  = wr_ok & (paddr == RSF_MASK_ADDR);
   assign wr_ctrl  = wr_ok & (paddr == RSF_CTRL_ADDR);
   assign rd_stat  = access & ~pwrite & (paddr == RSF_STAT_ADDR);
   assign cnt_clr  = wr_ctrl & pwdata[RSF_CTRL_CNT_CLR];

   // Event set vector at the flag positions.
   always_comb begin
      flag_set = 8'h00;
      flag_set[RSF_BIT_LV]   = events.lv;
      flag_set[RSF_BIT_WDOG] = events.wdog;
      flag_set[RSF_BIT_OSC]  = events.osc;
      flag_set[RSF_BIT_PLL]  = events.pll;
   end

   // clear only where a one is written.
   assign flag_clr = wr_cause ? (pwdata[7:0] & RSF_FLAGS_IMPL) : 8'h00;

   // One cell per implemented bit; the others stay zero.
   // power-on loads the flags.
   // presetn does not reach the cells.
   genvar gi;
   generate
      for (gi = 0; gi < RSF_REG_W; gi++) begin : g_flag
         if (RSF_FLAGS_IMPL[gi]) begin : g_impl
            rsf_flag_cell #(
               .POR_VALUE (RSF_FLAGS_POR[gi])
            ) u_cell (
               .pclk  (pclk),
               .por_n (por_n),
               .set   (flag_set[gi]),
               .clr   (flag_clr[gi]),
               .flag  (flags[gi])
            );
         end else begin : g_zero
            assign flags[gi] = 1'b0;
         end
      end
   endgenerate

   assign cause_flags = flags;

   // Copy of the flags under system reset. It restarts at zero, so
   // every flag still set after a restart raises its status once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_reg <= RSF_STAT_RST;
      end else begin
         seen_reg <= flags;
      end
   end

   assign flag_rise = flags & ~seen_reg;

   // Status: set by a rising flag, cleared by reading it. Only the
   // bits returned by that read are cleared, and a set wins.
   always_comb begin
      stat_next = stat_reg;
      if (rd_stat) begin
         stat_next = stat_next & ~stat_cap_reg;
      end
      stat_next = stat_next | flag_rise;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_reg <= RSF_STAT_RST;
      end else begin
         stat_reg <= stat_next;
      end
   end

   // Interrupt mask, same layout as the status.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= RSF_MASK_RST;
      end else if (wr_mask) begin
         mask_reg <= pwdata[7:0] & RSF_FLAGS_IMPL;
      end
   end

   // Interrupt level, one cycle behind status and mask.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(stat_reg & mask_reg);
      end
   end

   assign irq = irq_reg;

   // Most recent cause; kept across system resets. Where events
   // coincide the first of low-voltage, watchdog, oscillator, PLL wins.
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         last_reg <= RSF_C_POR;
      end else if (events.lv) begin
         last_reg <= RSF_C_LV;
      end else if (events.wdog) begin
         last_reg <= RSF_C_WDOG;
      end else if (events.osc) begin
         last_reg <= RSF_C_OSC;
      end else if (events.pll) begin
         last_reg <= RSF_C_PLL;
      end
   end

   // Saturating event counters, kept across system resets. A clear
   // in the cycle of an event leaves a count of one.
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         cnt_lv_reg   <= RSF_CNT_RST;
         cnt_wdog_reg <= RSF_CNT_RST;
         cnt_osc_reg  <= RSF_CNT_RST;
         cnt_pll_reg  <= RSF_CNT_RST;
      end else if (cnt_clr) begin
         cnt_lv_reg   <= {7'h00, events.lv};
         cnt_wdog_reg <= {7'h00, events.wdog};
         cnt_osc_reg  <= {7'h00, events.osc};
         cnt_pll_reg  <= {7'h00, events.pll};
      end else begin
         cnt_lv_reg   <= sat_inc(cnt_lv_reg, events.lv);
         cnt_wdog_reg <= sat_inc(cnt_wdog_reg, events.wdog);
         cnt_osc_reg  <= sat_inc(cnt_osc_reg, events.osc);
         cnt_pll_reg  <= sat_inc(cnt_pll_reg, events.pll);
      end
   end

   // Read data and error are taken in the setup cycle and stand
   // through the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg   <= 32'h0000_0000;
         pslverr_reg  <= 1'b0;
         stat_cap_reg <= RSF_STAT_RST;
      end else if (setup) begin
         prdata_reg   <= 32'h0000_0000;
         stat_cap_reg <= RSF_STAT_RST;
         pslverr_reg  <= ~addr_mapped(paddr) |
                         (pwrite & addr_read_only(paddr));
         if (!pwrite) begin
            case (paddr)
               RSF_CAUSE_ADDR: begin
                  prdata_reg <= {24'h000000, flags};
               end
               RSF_STAT_ADDR: begin
                  prdata_reg   <= {24'h000000, stat_reg};
                  stat_cap_reg <= stat_reg;
               end
               RSF_MASK_ADDR: begin
                  prdata_reg <= {24'h000000, mask_reg};
               end
               RSF_LAST_ADDR: begin
                  prdata_reg <= {29'h00000000, last_reg};
               end
               RSF_CNT_ADDR: begin
                  prdata_reg <= {cnt_pll_reg, cnt_osc_reg,
                                 cnt_wdog_reg, cnt_lv_reg};
               end
               default: begin
                  prdata_reg <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // Outputs hold zero outside the access cycle.
   assign prdata  = access ? prdata_reg : 32'h0000_0000;
   assign pslverr = access & pslverr_reg;

endmodule

// [testbench/rsf_reset_cause_assertions.sv]
// Concurrent checks on the reset cause block's top ports.
// Assumes a bind to rsf_reset_cause; por_n and presetn are both resets.
`timescale 1ns/10ps

module rsf_checker
   import rsf_pkg::*;
(
   input wire logic                  pclk,        // Bus clock.
   input wire logic                  presetn,     // System reset.
   input wire logic                  por_n,       // Power-on reset.
   input wire logic [RSF_ADDR_W-1:0] paddr,       // APB address.
   input wire logic                  psel,        // APB select.
   input wire logic                  penable,     // APB enable.
   input wire logic                  pwrite,      // APB direction.
   input wire logic [RSF_DATA_W-1:0] pwdata,      // APB write data.
   input wire logic [3:0]            pstrb,       // APB byte lanes.
   input wire logic [RSF_DATA_W-1:0] prdata,      // APB read data.
   input wire rsf_events_s           events,      // Source events.
   input wire logic [RSF_REG_W-1:0]  cause_flags  // Flag register.
);
   logic       wr_flags;
   logic [7:0] wlo;

   // Access phase of a write that targets the flag register.
   assign wr_flags = psel && penable && pwrite && paddr == RSF_CAUSE_ADDR;
   assign wlo = pwdata[7:0];

   a_lv_flag: assert property (
      @(posedge pclk) disable iff (!por_n) events.lv |=> cause_flags[5])
      else $error("low-voltage flag not set");
   a_wdog_flag: assert property (
      @(posedge pclk) disable iff (!por_n) events.wdog |=> cause_flags[3])
      else $error("watchdog flag not set");
   a_osc_flag: assert property (
      @(posedge pclk) disable iff (!por_n) events.osc |=> cause_flags[1])
      else $error("oscillator flag not set");
   a_pll_flag: assert property (
      @(posedge pclk) disable iff (!por_n) events.pll |=> cause_flags[0])
      else $error("pll flag not set");
   a_por_load: assert property (
      @(posedge pclk) disable iff (!por_n)
      $rose(por_n) |-> cause_flags == 8'h60)
      else $error("power-on value wrong");
   a_flags_hold: assert property (
      @(posedge pclk) disable iff (!por_n)
      (events == 4'h0 && !(wr_flags && pstrb[0]))
      |=> $stable(cause_flags))
      else $error("flags changed without cause");
   a_w1c_clear: assert property (
      @(posedge pclk) disable iff (!presetn || !por_n)
      (wr_flags && pstrb[0] && events == 4'h0)
      |=> cause_flags == ($past(cause_flags) & ~$past(wlo)))
      else $error("write-one clear wrong");
   a_read_flags: assert property (
      @(posedge pclk) disable iff (!presetn || !por_n)
      (psel && penable && !pwrite && paddr == RSF_CAUSE_ADDR)
      |-> prdata == {24'h000000, $past(cause_flags)})
      else $error("flag read data wrong");
   a_unimpl_zero: assert property (
      @(posedge pclk) disable iff (!por_n) (cause_flags & 8'h94) == 8'h00)
      else $error("unused flag bit set");
endmodule

bind rsf_reset_cause rsf_checker u_rsf_checker (.pclk, .presetn,
   .por_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
   .events, .cause_flags);

// [testbench/rsf_reset_cause_bench.sv]
// Self-checking bench for the reset cause block.
// Assumes the block answers APB with pready; the checker is bound.
`timescale 1ns/10ps

`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) \
   begin fails++; $display("BAD %s exp %h got %h", nm, ex, gt); end end

module rsf_reset_cause_bench
   import rsf_pkg::*;
;
   localparam logic [7:0] BITS [4] = '{8'h20, 8'h08, 8'h02, 8'h01};
   logic                  pclk    = 1'b0;
   logic                  presetn = 1'b0;
   logic                  por_n   = 1'b0;
   logic [RSF_ADDR_W-1:0] paddr   = 8'h00;
   logic                  psel    = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite  = 1'b0;
   logic [RSF_DATA_W-1:0] pwdata  = 32'h0;
   logic [3:0]            pstrb   = 4'hf;
   rsf_events_s           events  = 4'h0;
   logic [RSF_DATA_W-1:0] prdata, rd;
   logic [RSF_REG_W-1:0]  cause_flags;
   logic                  pready, pslverr, irq, er;
   int                    fails = 0, samples_checked = 0, cyc = 0;

   rsf_reset_cause u_rsf_reset_cause (.pclk, .presetn, .por_n, .paddr,
      .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .events, .cause_flags, .irq);

   // Free-running 25 MHz clock.
   always #20 pclk = ~pclk;

   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Cuts a hung run short.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         end_sim();
      end
   end

   // One APB transfer; waits for pready, then settles to a falling edge.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask

   // Shorthand for full-word reads and writes.
   task automatic rdr(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 4'hf);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask

   // Drives one single-cycle event word.
   task automatic pulse(input logic [3:0] e);
      @(posedge pclk);
      events <= rsf_events_s'(e);
      @(posedge pclk);
      events <= 4'h0;
      @(negedge pclk);
   endtask

   // Power-up leaves only the power-on and low-voltage flags.
   task automatic t_por();
      rdr(RSF_CAUSE_ADDR);
      `CHK("power-up flags", 32'h60, rd)
      `CHK("flag read err", 1'b0, er)
   endtask

   // Each source sets its own flag alone.
   task automatic t_src();
      wr(RSF_CAUSE_ADDR, 32'hff);
      `CHK("all cleared", 8'h00, cause_flags)
      for (int i = 0; i < 4; i++) begin
         pulse(4'h8 >> i);
         `CHK("source flag", BITS[i], cause_flags)
         wr(RSF_CAUSE_ADDR, {24'h0, BITS[i]});
      end
   endtask

   // Zeros, disabled lanes and unused bits leave flags alone.
   task automatic t_w1c();
      pulse(4'hf);
      wr(RSF_CAUSE_ADDR, 32'h0);
      `CHK("zero write", 8'h2b, cause_flags)
      apb(1'b1, RSF_CAUSE_ADDR, 32'hff, 4'h0);
      `CHK("lane off", 8'h2b, cause_flags)
      wr(RSF_CAUSE_ADDR, 32'h08);
      `CHK("single clear", 8'h23, cause_flags)
      wr(RSF_CAUSE_ADDR, 32'h94);
      rdr(RSF_CAUSE_ADDR);
      `CHK("unused bits", 32'h23, rd)
   endtask

   // System reset keeps flags; power-on reloads them.
   task automatic t_sys();
      pulse(4'h4);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      `CHK("system reset", 8'h2b, cause_flags)
      wr(RSF_CAUSE_ADDR, 32'h20);
      @(posedge pclk);
      por_n <= 1'b0;
      repeat (4) @(posedge pclk);
      por_n <= 1'b1;
      @(negedge pclk);
      `CHK("power-on", 8'h60, cause_flags)
   endtask

   // Masked and unmasked interrupt, read-clear, unmapped address.
   task automatic t_irq();
      rdr(RSF_STAT_ADDR);
      wr(RSF_CAUSE_ADDR, 32'hff);
      wr(RSF_MASK_ADDR, 32'h08);
      pulse(4'h4);
      repeat (2) @(negedge pclk);
      `CHK("irq raised", 1'b1, irq)
      rdr(RSF_STAT_ADDR);
      `CHK("status", 32'h08, rd)
      @(negedge pclk);
      `CHK("irq cleared", 1'b0, irq)
      pulse(4'h2);
      repeat (2) @(negedge pclk);
      `CHK("irq masked", 1'b0, irq)
      rdr(RSF_STAT_ADDR);
      `CHK("status osc", 32'h02, rd)
      rdr(8'h40);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 32'h0, rd)
   endtask

   // Last cause, event counters, their clear and read-only refusal.
   task automatic t_own();
      rdr(RSF_LAST_ADDR);
      `CHK("last cause", 32'h3, rd)
      rdr(RSF_CNT_ADDR);
      `CHK("counters", 32'h0001_0100, rd)
      pulse(4'hf);
      rdr(RSF_LAST_ADDR);
      `CHK("last priority", 32'h1, rd)
      rdr(RSF_CNT_ADDR);
      `CHK("counters all", 32'h0102_0201, rd)
      wr(RSF_CNT_ADDR, 32'h0);
      `CHK("ro write err", 1'b1, er)
      wr(RSF_CTRL_ADDR, 32'h1);
      `CHK("ctrl write err", 1'b0, er)
      rdr(RSF_CNT_ADDR);
      `CHK("counters cleared", 32'h0, rd)
      `CHK("ready", 1'b1, pready)
   endtask

   // Reset for 16 cycles, then the scenarios in turn.
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
      t_por();
      t_src();
      t_w1c();
      t_sys();
      t_irq();
      t_own();
      end_sim();
   end
endmodule
